// ===== pmw_regs.svh
// constants of the power mode and wakeup controller
`ifndef PMW_REGS_SVH
`define PMW_REGS_SVH
`define PMW_MODE_NORMAL 2'h0
`define PMW_MODE_SLEEP 2'h1
`define PMW_MODE_GREEN 2'h2
`define PMW_MODE_RSVD 2'h3
`define PMW_WAKE_CYCLES 16384
`define PMW_WAKE_CNT_W 15
`endif

// ===== pmw_pkg.sv
// types of the power mode and wakeup controller
`default_nettype none
package pmw_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_GREEN,
    ST_SLEEP,
    ST_OSC_WAIT,
    ST_STABLE
  } pmw_state_e;
endpackage
`default_nettype wire

// ===== pmw_wake_if.sv
// wake trigger bundle between detector and controller
`timescale 1ns/100ps
`default_nettype none
interface pmw_wake_if;
  logic pin_change;
  logic usb_toggle;
  logic timer_ovf;
  modport src (output pin_change, output usb_toggle, output timer_ovf);
  modport dst (input pin_change, input usb_toggle, input timer_ovf);
endinterface
`default_nettype wire

// ===== pmw_wake_detect.sv
// wake trigger edge detector for the two wake ports
`timescale 1ns/100ps
`default_nettype none
module pmw_wake_detect #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // raw sources
  input wire logic [PORT_W-1:0] wake_port_a,
  input wire logic [PORT_W-1:0] wake_port_b,
  input wire logic usb_bus_toggle,
  input wire logic wake_timer_ovf,
  // triggers
  pmw_wake_if.src wake
);
  typedef struct packed {
    logic [PORT_W-1:0] a;
    logic [PORT_W-1:0] b;
    logic primed;
  } pmw_det_s;
  pmw_det_s q, d;

  always_comb
  begin
    d = q;
    d.a = wake_port_a;
    d.b = wake_port_b;
    d.primed = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      q <= '0;
    else
      q <= d;
  end

  // level change on either port
  assign wake.pin_change = q.primed && ((q.a != wake_port_a) || (q.b != wake_port_b));
  assign wake.usb_toggle = usb_bus_toggle;
  assign wake.timer_ovf = wake_timer_ovf;
endmodule
`default_nettype wire

// ===== pmw_ctrl.sv
// operating mode and wakeup controller
// Summary of operation
// - mode field 00 normal, 01 sleep, 10 green, 11 reserved.
// - slow select 0 runs high clock, 1 runs low RC clock.
// - high oscillator stop bit halts only the high oscillator.
// - instruction execution halts in sleep and green until wakeup.
// - wake triggers are port change, timer overflow, usb toggle.
// - sleep wakes only on port change or usb toggle, to normal.
// - green wakeup returns to the prior normal or slow mode.
// - timer wake disabled leaves green only on pin change, usb toggle or reset.
// - timer wake enabled also leaves green on timer overflow.
// - high oscillator stopped throughout sleep.
// - after sleep wakeup count 16384 clocks once oscillator started.
// - green wakeup resumes at once with no delay.
// - watchdog runs purely by its build option in every mode.
`timescale 1ns/100ps
`default_nettype none
`include "pmw_regs.svh"
module pmw_ctrl #(
  parameter int PORT_W = 8,
  parameter int WAKE_CYCLES = `PMW_WAKE_CYCLES,
  parameter bit WDT_OPTION = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // software controls
  input wire logic [1:0] cpu_mode_field,
  input wire logic cpu_mode_wr,
  input wire logic slow_clock_select,
  input wire logic high_osc_stop,
  input wire logic wake_timer_enable,
  // wake sources and high oscillator ready
  input wire logic [PORT_W-1:0] wake_port_a,
  input wire logic [PORT_W-1:0] wake_port_b,
  input wire logic usb_bus_toggle,
  input wire logic wake_timer_ovf,
  input wire logic high_osc_ready,
  // clock and core controls
  output logic ext_high_oscillator_en,
  output logic internal_low_rc_osc_en,
  output logic sys_clk_sel_low,
  output logic cpu_run,
  output logic wdt_run,
  // status
  output logic [1:0] mode_status,
  output logic wake_pulse
);
  localparam int CW = `PMW_WAKE_CNT_W;
  typedef struct packed {
    pmw_pkg::pmw_state_e st;
    logic [CW-1:0] cnt;
    logic slow;
    logic hosc;
    logic lrc;
    logic run;
    logic wdt;
    logic [1:0] mode;
    logic wake;
  } pmw_ctrl_s;
  pmw_ctrl_s q, d;
  pmw_wake_if wk ();

  pmw_wake_detect #(.PORT_W(PORT_W)) u_det (
    .clk(clk),
    .reset_n(reset_n),
    .wake_port_a(wake_port_a),
    .wake_port_b(wake_port_b),
    .usb_bus_toggle(usb_bus_toggle),
    .wake_timer_ovf(wake_timer_ovf),
    .wake(wk)
  );

  logic ext_wake;
  logic green_wake;
  assign ext_wake = wk.pin_change || wk.usb_toggle;
  assign green_wake = ext_wake || (wake_timer_enable && wk.timer_ovf);

  always_comb
  begin
    d = q;
    d.wake = 1'b0;
    d.wdt = WDT_OPTION;
    case (q.st)
      pmw_pkg::ST_RUN:
      begin
        d.slow = slow_clock_select;
        d.hosc = !high_osc_stop;
        d.lrc = 1'b1;
        d.run = 1'b1;
        d.mode = `PMW_MODE_NORMAL;
        if (cpu_mode_wr && cpu_mode_field == `PMW_MODE_SLEEP)
        begin
          d.st = pmw_pkg::ST_SLEEP;
          d.hosc = 1'b0;
          d.lrc = 1'b0;
          d.run = 1'b0;
          d.mode = `PMW_MODE_SLEEP;
        end
        else if (cpu_mode_wr && cpu_mode_field == `PMW_MODE_GREEN)
        begin
          d.st = pmw_pkg::ST_GREEN;
          d.run = 1'b0;
          d.mode = `PMW_MODE_GREEN;
        end
      end
      pmw_pkg::ST_GREEN:
      begin
        d.hosc = !high_osc_stop;
        if (green_wake)
        begin
          d.st = pmw_pkg::ST_RUN;
          d.run = 1'b1;
          d.wake = 1'b1;
          d.mode = `PMW_MODE_NORMAL;
        end
      end
      pmw_pkg::ST_SLEEP:
      begin
        if (ext_wake)
        begin
          d.st = pmw_pkg::ST_OSC_WAIT;
          d.hosc = 1'b1;
          d.lrc = 1'b1;
          d.slow = 1'b0;
        end
      end
      pmw_pkg::ST_OSC_WAIT:
      begin
        d.cnt = '0;
        if (high_osc_ready)
          d.st = pmw_pkg::ST_STABLE;
      end
      pmw_pkg::ST_STABLE:
      begin
        d.cnt = q.cnt + CW'(1);
        if (q.cnt == CW'(WAKE_CYCLES - 1))
        begin
          d.st = pmw_pkg::ST_RUN;
          d.run = 1'b1;
          d.wake = 1'b1;
          d.mode = `PMW_MODE_NORMAL;
        end
      end
      default:
        d.st = pmw_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      q <= '0;
      q.st <= pmw_pkg::ST_RUN;
      q.hosc <= 1'b1;
      q.lrc <= 1'b1;
      q.run <= 1'b1;
      q.wdt <= WDT_OPTION;
    end
    else
      q <= d;
  end

  assign ext_high_oscillator_en = q.hosc;
  assign internal_low_rc_osc_en = q.lrc;
  assign sys_clk_sel_low = q.slow;
  assign cpu_run = q.run;
  assign wdt_run = q.wdt;
  assign mode_status = q.mode;
  assign wake_pulse = q.wake;

  chk_sleep_osc_off: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_SLEEP |-> !ext_high_oscillator_en && !cpu_run)
    else $error("high oscillator or core running in sleep");
  chk_green_halt: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN |-> !cpu_run)
    else $error("core running in green mode");
  chk_green_wake_now: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN && green_wake |=> cpu_run && wake_pulse)
    else $error("green wakeup not immediate");
  chk_green_keep_slow: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN |=> $stable(sys_clk_sel_low))
    else $error("slow select lost across green");
  chk_green_no_timer: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN && !ext_wake && !wake_timer_enable |=> q.st == pmw_pkg::ST_GREEN)
    else $error("green left without pin trigger");
  chk_green_timer: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN && wake_timer_enable && wk.timer_ovf |=> q.st == pmw_pkg::ST_RUN)
    else $error("timer overflow did not wake green");
  chk_sleep_timer_ign: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_SLEEP && !ext_wake |=> q.st == pmw_pkg::ST_SLEEP)
    else $error("sleep left without external trigger");
  chk_stable_count: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_STABLE && q.cnt == '0 |-> !cpu_run [*8])
    else $error("core resumed during stabilisation");
  chk_stable_end: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_STABLE && q.cnt == CW'(WAKE_CYCLES - 1) |=> cpu_run && !sys_clk_sel_low)
    else $error("stabilisation end wrong");
  chk_run_clock: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_RUN |=>
      sys_clk_sel_low == $past(slow_clock_select) || q.st != pmw_pkg::ST_RUN)
    else $error("clock select not followed");
  chk_lrc_running: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_RUN |-> internal_low_rc_osc_en)
    else $error("low rc stopped outside sleep");
  chk_wdt_opt: assert property (@(posedge clk) disable iff (!reset_n)
    wdt_run == WDT_OPTION)
    else $error("watchdog not per option");
  cov_sleep_wake: cover property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_STABLE ##1 q.st == pmw_pkg::ST_RUN);
  cov_green_pin: cover property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN && wk.pin_change);
  cov_green_timer: cover property (@(posedge clk) disable iff (!reset_n)
    q.st == pmw_pkg::ST_GREEN && wake_timer_enable && wk.timer_ovf);
endmodule
`default_nettype wire

// ===== pmw_osc_model.sv
// far-side model of the high oscillator start-up
`timescale 1ns/100ps
`default_nettype none
module pmw_osc_model #(
  parameter int START_CYCLES = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // oscillator
  input wire logic osc_en,
  output logic osc_ready
);
  int cnt;
  // ready only after the start-up time, dropped at once on stop
  always_ff @(posedge clk)
  begin
    if (!reset_n || !osc_en)
    begin
      cnt <= 0;
      osc_ready <= 1'b0;
    end
    else if (cnt < START_CYCLES)
    begin
      cnt <= cnt + 1;
    end
    else
    begin
      osc_ready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== power_mode_wakeup_control_bench.sv
// self-checking bench of the mode and wakeup controller
`timescale 1ns/100ps
`default_nettype none
module power_mode_wakeup_control_bench;
  localparam int WC = 8;
  logic clk, reset_n, wr, slow, hstop, ten, usb, ovf, rdy;
  logic hen, len, sel, run, wdt, wp;
  logic [1:0] field, ms;
  logic [7:0] pa, pb, st;
  int n_errors = 0;
  int checked = 0;
  int n;
  assign st = {hen, len, sel, run, wdt, wp, ms};
  pmw_ctrl #(.WAKE_CYCLES(WC)) uut (.clk(clk), .reset_n(reset_n), .cpu_mode_field(field),
    .cpu_mode_wr(wr), .slow_clock_select(slow), .high_osc_stop(hstop),
    .wake_timer_enable(ten), .wake_port_a(pa), .wake_port_b(pb), .usb_bus_toggle(usb),
    .wake_timer_ovf(ovf), .high_osc_ready(rdy), .ext_high_oscillator_en(hen),
    .internal_low_rc_osc_en(len), .sys_clk_sel_low(sel), .cpu_run(run), .wdt_run(wdt),
    .mode_status(ms), .wake_pulse(wp));
  pmw_osc_model osc (.clk(clk), .reset_n(reset_n), .osc_en(hen), .osc_ready(rdy));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr_mode(input logic [1:0] m);
    field = m;
    wr = 1'b1;
    step(1);
    wr = 1'b0;
    step(1);
  endtask
  // bounded wait on a level of the oscillator ready or cpu_run
  task automatic wait_for(input bit on_run);
    n = 0;
    while (((on_run ? run : rdy) !== 1'b1) && n < 60)
    begin
      step(1);
      n++;
    end
    if (n >= 60)
    begin
      n_errors++;
      end_sim();
    end
  endtask
  initial
  begin
    {reset_n, wr, slow, hstop, ten, usb, ovf, field, pa, pb} = '0;
    step(5);
    reset_n = 1'b1;
    step(2);
    chk(st, 8'hD8);
    wr_mode(2'h3);
    chk(st, 8'hD8);
    wr_mode(2'h0);
    chk(st, 8'hD8);
    wr_mode(2'h2);
    chk(st, 8'hCA);
    ovf = 1'b1;
    step(1);
    ovf = 1'b0;
    step(2);
    chk(st, 8'hCA);
    pa = 8'h01;
    step(1);
    chk(st, 8'hDC);
    step(1);
    chk(st, 8'hD8);
    wr_mode(2'h2);
    ten = 1'b1;
    ovf = 1'b1;
    step(1);
    ovf = 1'b0;
    chk(st, 8'hDC);
    pb = 8'h80;
    wr_mode(2'h1);
    chk(st, 8'h09);
    ovf = 1'b1;
    step(1);
    ovf = 1'b0;
    step(3);
    chk(st, 8'h09);
    usb = 1'b1;
    step(1);
    usb = 1'b0;
    chk({7'h0, hen}, 8'h01);
    wait_for(1'b0);
    chk(st, 8'hC9);
    wait_for(1'b1);
    chk({7'h0, n >= WC && n <= WC + 2}, 8'h01);
    chk(st, 8'hDC);
    slow = 1'b1;
    step(2);
    chk(st, 8'hF8);
    hstop = 1'b1;
    step(2);
    chk(st, 8'h78);
    wr_mode(2'h2);
    chk(st, 8'h6A);
    pb = 8'h00;
    step(1);
    chk(st, 8'h7C);
    hstop = 1'b0;
    wait_for(1'b0);
    slow = 1'b0;
    step(2);
    chk(st, 8'hD8);
    end_sim();
  end
endmodule
`default_nettype wire
